// *** common/spic_pkg.sv ***
// Shared constants and carrier types of the power, interrupt and format control block
package spic_pkg;

	// Register offsets on the device's register port
	localparam logic [7:0] SPIC_OFS_POWER  = 8'h2D;
	localparam logic [7:0] SPIC_OFS_ENABLE = 8'h2E;
	localparam logic [7:0] SPIC_OFS_ROUTE  = 8'h2F;
	localparam logic [7:0] SPIC_OFS_FLAGS  = 8'h30;
	localparam logic [7:0] SPIC_OFS_FORMAT = 8'h31;

	// Reset values
	localparam logic [7:0] SPIC_RST_POWER  = 8'h00;
	localparam logic [7:0] SPIC_RST_ENABLE = 8'h00;
	localparam logic [7:0] SPIC_RST_ROUTE  = 8'h00;
	localparam logic [7:0] SPIC_RST_FLAGS  = 8'h02;
	localparam logic [7:0] SPIC_RST_FORMAT = 8'h00;

	// Bits that hold storage; all others read zero and ignore writes
	localparam logic [7:0] SPIC_MASK_POWER  = 8'h3F;
	localparam logic [7:0] SPIC_MASK_IRQ    = 8'h9B;
	localparam logic [7:0] SPIC_MASK_FORMAT = 8'hEF;

	// Power control fields
	localparam int SPIC_PWR_LINK    = 5;
	localparam int SPIC_PWR_AUTO    = 4;
	localparam int SPIC_PWR_MEASURE = 3;
	localparam int SPIC_PWR_SLEEP   = 2;
	localparam int SPIC_PWR_DOZE_LO = 0;

	// Shared interrupt bit layout
	localparam int SPIC_IRQ_DREADY = 7;
	localparam int SPIC_IRQ_ACT    = 4;
	localparam int SPIC_IRQ_INACT  = 3;
	localparam int SPIC_IRQ_WMARK  = 1;
	localparam int SPIC_IRQ_OVRUN  = 0;

	// Format control fields
	localparam int SPIC_FMT_SELFTEST = 7;
	localparam int SPIC_FMT_WIRE3    = 6;
	localparam int SPIC_FMT_INVERT   = 5;
	localparam int SPIC_FMT_WIDE     = 3;
	localparam int SPIC_FMT_LEFT     = 2;
	localparam int SPIC_FMT_RANGE_LO = 0;

	// Sleep-mode reading rates in Hz, by doze code
	localparam logic [3:0] SPIC_DOZE_HZ_0 = 4'h8;
	localparam logic [3:0] SPIC_DOZE_HZ_1 = 4'h4;
	localparam logic [3:0] SPIC_DOZE_HZ_2 = 4'h2;
	localparam logic [3:0] SPIC_DOZE_HZ_3 = 4'h1;

	// Sample widths
	localparam int SPIC_NARROW_BITS = 10;
	localparam int SPIC_RAW_BITS    = 13;
	localparam int SPIC_OUT_BITS    = 16;
	localparam logic [1:0] SPIC_RANGE_WIDEST = 2'h3;

	typedef enum logic [0:0] {
		SPIC_SEEK_INACT,
		SPIC_SEEK_ACT
	} spic_link_t;

	// Event pulses from detectors and the sample path
	typedef struct packed {
		logic dready;
		logic act;
		logic inact;
		logic wmark;
		logic ovrun;
	} spic_evt_t;

	typedef struct packed {
		logic [7:0] power;
		logic [7:0] enable;
		logic [7:0] route;
		logic [7:0] flags;
		logic [7:0] format;
		logic [7:0] rdata;
		spic_link_t link;
		logic       auto_asleep;
		logic       pin_a;
		logic       pin_b;
		logic [15:0] sample;
		logic       sample_vld;
		logic       meas_out;
		logic       sleep_out;
		logic       fifo_out;
		logic [3:0] doze_out;
		logic       act_out;
		logic       inact_out;
	} spic_state_t;

endpackage

// *** hdl/spic_ctl.sv ***
// Power-mode, interrupt and output-format control registers of the accelerometer
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Linked mode: activity waits for inactivity, alternating.
// - Unlinked: both detectors run independently.
// - Linked plus auto bit: sleep on inactivity.
// - Measure bit selects standby or measurement.
// - Power-up lands in standby.
// - Sleep suppresses sample event, FIFO writes; doze rate.
// - Asleep, only activity detection runs.
// - Doze code picks 8, 4, 2, 1 Hz.
// - Enable bit permits or blocks each interrupt.
// - Data, watermark, overrun flags ignore enables.
// - Routing bit picks pin; pins OR routed interrupts.
// - Enable, routing, flags share one bit layout.
// - Data flags clear on axis data reads.
// - Reading flags register clears activity, inactivity.
// - Self-test bit applies sensor stimulus.
// - Wire-count bit selects 3-wire or 4-wire.
// - Polarity bit inverts interrupt pins.
// - Wide scale keeps fixed LSB; else 10-bit.
// - Justify bit: left aligned or sign-extended right.
// - Range field picks 1.5, 3, 6, 12 g.
// - Saturate outputs except in widest range.
// - No auto sleep while activity flag pending.
module spic_ctl (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [7:0]           reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [7:0]           reg_rdata_o,
	input  wire spic_pkg::spic_evt_t  evt_i,
	input  wire logic                 axis_data_read_i,
	input  wire logic                 raw_vld_i,
	input  wire logic signed [12:0]   raw_sample_i,
	output logic      [15:0]          sample_o,
	output logic                      sample_vld_o,
	output logic                      irq_pin_a_o,
	output logic                      irq_pin_b_o,
	output logic                      measure_mode_o,
	output logic                      sleep_mode_o,
	output logic                      fifo_write_en_o,
	output logic      [3:0]           doze_hz_o,
	output logic                      act_detect_en_o,
	output logic                      inact_detect_en_o,
	output logic                      self_test_o,
	output logic                      wire3_mode_o
);

	spic_pkg::spic_state_t st_r;
	spic_pkg::spic_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Sample formatting

	function automatic logic [15:0] spic_format(
		input logic signed [12:0] raw,
		input logic [7:0]         fmt
	);
		logic [1:0]         rng;
		logic               wide;
		int                 width;
		logic signed [15:0] val;
		logic signed [15:0] vmax;
		logic signed [15:0] vmin;
		logic [15:0]        res;
		rng   = fmt[spic_pkg::SPIC_FMT_RANGE_LO +: 2];
		wide  = fmt[spic_pkg::SPIC_FMT_WIDE];
		val   = 16'(raw);
		width = spic_pkg::SPIC_NARROW_BITS;
		// Narrow mode coarsens the LSB with the range; wide mode grows the width
		if (wide)
		begin
			width = spic_pkg::SPIC_NARROW_BITS + int'(rng);
		end
		else
		begin
			val = val >>> rng;
		end
		vmax = 16'((32'sd1 <<< (width - 1)) - 1);
		vmin = -vmax - 16'sh0001;
		// Clipping avoids rollover; the widest range always fits
		if (rng != spic_pkg::SPIC_RANGE_WIDEST)
		begin
			if (val > vmax)
			begin
				val = vmax;
			end
			else if (val < vmin)
			begin
				val = vmin;
			end
		end
		if (fmt[spic_pkg::SPIC_FMT_LEFT])
		begin
			res = 16'(val) << (spic_pkg::SPIC_OUT_BITS - width);
		end
		else
		begin
			res = 16'(val);
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	logic       measure;
	logic       sleeping;
	logic       linked;
	logic       act_ok;
	logic       inact_ok;
	logic       flags_read;
	logic [7:0] set_v;
	logic [7:0] clr_v;
	logic [7:0] pend;
	logic       any_a;
	logic       any_b;

	always_comb
	begin
		st_nxt     = st_r;
		measure    = st_r.power[spic_pkg::SPIC_PWR_MEASURE];
		sleeping   = st_r.power[spic_pkg::SPIC_PWR_SLEEP] | st_r.auto_asleep;
		linked     = st_r.power[spic_pkg::SPIC_PWR_LINK]
			& st_r.enable[spic_pkg::SPIC_IRQ_ACT]
			& st_r.enable[spic_pkg::SPIC_IRQ_INACT];
		flags_read = reg_rd_i && (reg_addr_i == spic_pkg::SPIC_OFS_FLAGS);

		// Linked mode alternates the two detectors; unlinked both run, inactivity only while awake
		act_ok   = measure & st_r.enable[spic_pkg::SPIC_IRQ_ACT]
			& (~linked | (st_r.link == spic_pkg::SPIC_SEEK_ACT));
		inact_ok = measure & ~sleeping & st_r.enable[spic_pkg::SPIC_IRQ_INACT]
			& (~linked | (st_r.link == spic_pkg::SPIC_SEEK_INACT));

		set_v = 8'h00;
		clr_v = 8'h00;
		// Data path flags run regardless of enables; sample event is muted while asleep
		set_v[spic_pkg::SPIC_IRQ_DREADY] = evt_i.dready & measure & ~sleeping;
		set_v[spic_pkg::SPIC_IRQ_WMARK]  = evt_i.wmark;
		set_v[spic_pkg::SPIC_IRQ_OVRUN]  = evt_i.ovrun;
		set_v[spic_pkg::SPIC_IRQ_ACT]    = evt_i.act & act_ok;
		set_v[spic_pkg::SPIC_IRQ_INACT]  = evt_i.inact & inact_ok;
		if (axis_data_read_i)
		begin
			clr_v[spic_pkg::SPIC_IRQ_DREADY] = 1'b1;
			clr_v[spic_pkg::SPIC_IRQ_WMARK]  = 1'b1;
			clr_v[spic_pkg::SPIC_IRQ_OVRUN]  = 1'b1;
		end
		if (flags_read)
		begin
			clr_v[spic_pkg::SPIC_IRQ_ACT]   = 1'b1;
			clr_v[spic_pkg::SPIC_IRQ_INACT] = 1'b1;
		end
		// A new event in the clearing cycle survives
		st_nxt.flags = ((st_r.flags & ~clr_v) | set_v) & spic_pkg::SPIC_MASK_IRQ;

		// Link sequencing and automatic sleep
		if (!linked || !measure)
		begin
			st_nxt.link        = spic_pkg::SPIC_SEEK_INACT;
			st_nxt.auto_asleep = 1'b0;
		end
		else if (set_v[spic_pkg::SPIC_IRQ_INACT])
		begin
			st_nxt.link = spic_pkg::SPIC_SEEK_ACT;
			// A pending activity flag holds the part awake
			if (st_r.power[spic_pkg::SPIC_PWR_AUTO] && !st_r.flags[spic_pkg::SPIC_IRQ_ACT])
			begin
				st_nxt.auto_asleep = 1'b1;
			end
		end
		else if (set_v[spic_pkg::SPIC_IRQ_ACT])
		begin
			st_nxt.link        = spic_pkg::SPIC_SEEK_INACT;
			st_nxt.auto_asleep = 1'b0;
		end
		if (!st_r.power[spic_pkg::SPIC_PWR_AUTO])
		begin
			st_nxt.auto_asleep = 1'b0;
		end

		// Register writes
		if (reg_wr_i)
		begin
			if (reg_addr_i == spic_pkg::SPIC_OFS_POWER)
			begin
				st_nxt.power = reg_wdata_i & spic_pkg::SPIC_MASK_POWER;
			end
			else if (reg_addr_i == spic_pkg::SPIC_OFS_ENABLE)
			begin
				st_nxt.enable = reg_wdata_i & spic_pkg::SPIC_MASK_IRQ;
			end
			else if (reg_addr_i == spic_pkg::SPIC_OFS_ROUTE)
			begin
				st_nxt.route = reg_wdata_i & spic_pkg::SPIC_MASK_IRQ;
			end
			else if (reg_addr_i == spic_pkg::SPIC_OFS_FORMAT)
			begin
				st_nxt.format = reg_wdata_i & spic_pkg::SPIC_MASK_FORMAT;
			end
		end

		// Register reads; flags read out before this cycle's clear
		if (reg_rd_i)
		begin
			if (reg_addr_i == spic_pkg::SPIC_OFS_POWER)
			begin
				st_nxt.rdata = st_r.power;
			end
			else if (reg_addr_i == spic_pkg::SPIC_OFS_ENABLE)
			begin
				st_nxt.rdata = st_r.enable;
			end
			else if (reg_addr_i == spic_pkg::SPIC_OFS_ROUTE)
			begin
				st_nxt.rdata = st_r.route;
			end
			else if (reg_addr_i == spic_pkg::SPIC_OFS_FLAGS)
			begin
				st_nxt.rdata = st_r.flags;
			end
			else if (reg_addr_i == spic_pkg::SPIC_OFS_FORMAT)
			begin
				st_nxt.rdata = st_r.format;
			end
			else
			begin
				st_nxt.rdata = 8'h00;
			end
		end

		// Interrupt pins from the next flag state so a clear drops the pin at once
		pend  = st_nxt.flags & st_r.enable;
		any_a = |(pend & ~st_r.route);
		any_b = |(pend & st_r.route);
		st_nxt.pin_a = any_a ^ st_r.format[spic_pkg::SPIC_FMT_INVERT];
		st_nxt.pin_b = any_b ^ st_r.format[spic_pkg::SPIC_FMT_INVERT];

		// Mode outputs lag the power register by one cycle
		st_nxt.meas_out  = measure;
		st_nxt.sleep_out = sleeping;
		st_nxt.fifo_out  = measure & ~sleeping;
		case (st_r.power[spic_pkg::SPIC_PWR_DOZE_LO +: 2])
			2'h0: st_nxt.doze_out = spic_pkg::SPIC_DOZE_HZ_0;
			2'h1: st_nxt.doze_out = spic_pkg::SPIC_DOZE_HZ_1;
			2'h2: st_nxt.doze_out = spic_pkg::SPIC_DOZE_HZ_2;
			default: st_nxt.doze_out = spic_pkg::SPIC_DOZE_HZ_3;
		endcase
		st_nxt.act_out   = act_ok;
		st_nxt.inact_out = inact_ok;

		// Formatted sample, held until the next raw sample in measurement mode
		st_nxt.sample_vld = raw_vld_i & measure;
		if (raw_vld_i && measure)
		begin
			st_nxt.sample = spic_format(raw_sample_i, st_r.format);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r.power       <= spic_pkg::SPIC_RST_POWER;
			st_r.enable      <= spic_pkg::SPIC_RST_ENABLE;
			st_r.route       <= spic_pkg::SPIC_RST_ROUTE;
			st_r.flags       <= spic_pkg::SPIC_RST_FLAGS;
			st_r.format      <= spic_pkg::SPIC_RST_FORMAT;
			st_r.rdata       <= 8'h00;
			st_r.link        <= spic_pkg::SPIC_SEEK_INACT;
			st_r.auto_asleep <= 1'b0;
			st_r.pin_a       <= 1'b0;
			st_r.pin_b       <= 1'b0;
			st_r.sample      <= 16'h0000;
			st_r.sample_vld  <= 1'b0;
			st_r.meas_out    <= 1'b0;
			st_r.sleep_out   <= 1'b0;
			st_r.fifo_out    <= 1'b0;
			st_r.doze_out    <= spic_pkg::SPIC_DOZE_HZ_0;
			st_r.act_out     <= 1'b0;
			st_r.inact_out   <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, each a flip-flop or a flip-flop bit

	assign reg_rdata_o       = st_r.rdata;
	assign sample_o          = st_r.sample;
	assign sample_vld_o      = st_r.sample_vld;
	assign irq_pin_a_o       = st_r.pin_a;
	assign irq_pin_b_o       = st_r.pin_b;
	assign measure_mode_o    = st_r.meas_out;
	assign sleep_mode_o      = st_r.sleep_out;
	assign fifo_write_en_o   = st_r.fifo_out;
	assign doze_hz_o         = st_r.doze_out;
	assign act_detect_en_o   = st_r.act_out;
	assign inact_detect_en_o = st_r.inact_out;
	assign self_test_o       = st_r.format[spic_pkg::SPIC_FMT_SELFTEST];
	assign wire3_mode_o      = st_r.format[spic_pkg::SPIC_FMT_WIRE3];

endmodule

`default_nettype wire

// *** sim/spic_ctl_monitor.sv ***
// Checker of the control block's register port, modes and sample path
`timescale 1ns/10ps
`default_nettype none
module spic_ctl_monitor (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       raw_vld_i,
	input wire logic       sample_vld_o,
	input wire logic       measure_mode_o,
	input wire logic       sleep_mode_o,
	input wire logic       fifo_write_en_o,
	input wire logic [3:0] doze_hz_o,
	input wire logic       inact_detect_en_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
////////////////////////////////////////
chk_flag_layout: assert property (reg_rd_i && reg_addr_i == 8'h30 |=> (reg_rdata_o & 8'h64) == 8'h00)
	else $error("flag read shows a bit outside the layout");
chk_power_zero: assert property (reg_rd_i && reg_addr_i == 8'h2D |=> reg_rdata_o[7:6] == 2'h0)
	else $error("power read shows a fixed bit set");
chk_format_zero: assert property (reg_rd_i && reg_addr_i == 8'h31 |=> !reg_rdata_o[4])
	else $error("format read shows a fixed bit set");
chk_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside {[8'h2D:8'h31]}) |=> reg_rdata_o == 8'h00)
	else $error("unmapped read is not zero");
// Read data may only move on the edge after a read strobe
chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
	else $error("read data moved without a read");
chk_sample_cause: assert property (sample_vld_o |-> $past(raw_vld_i))
	else $error("sample valid without a raw sample");
chk_fifo_gate: assert property (fifo_write_en_o |-> measure_mode_o && !sleep_mode_o)
	else $error("fifo written in standby or sleep");
chk_sleep_act_only: assert property (sleep_mode_o |-> !inact_detect_en_o)
	else $error("inactivity detection runs asleep");
chk_doze_code: assert property (doze_hz_o inside {4'h8, 4'h4, 4'h2, 4'h1})
	else $error("doze rate not a legal value");
cov_flag_read: cover property (reg_rd_i && reg_addr_i == 8'h30);
cov_asleep: cover property (sleep_mode_o);
cov_sample: cover property (sample_vld_o);
endmodule
`default_nettype wire

// *** sim/spic_host_model.sv ***
// Host and sensor side model: register strobes, event pulses, raw samples
`timescale 1ns/10ps
`default_nettype none
module spic_host_model (
	input  wire logic                clk_i,
	input  wire logic [7:0]          reg_rdata_i,
	output var logic [7:0]           reg_addr_o,
	output var logic [7:0]           reg_wdata_o,
	output var logic                 reg_wr_o,
	output var logic                 reg_rd_o,
	output var spic_pkg::spic_evt_t  evt_o,
	output var logic                 axis_rd_o,
	output var logic                 raw_vld_o,
	output var logic signed [12:0]   raw_o
);
////////////////////////////////////////
initial
begin
	{reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
	{evt_o, axis_rd_o, raw_vld_o, raw_o} = '0;
end
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge clk_i);
	reg_addr_o  <= a;
	reg_wdata_o <= d;
	reg_wr_o    <= 1'b1;
	@(posedge clk_i);
	reg_wr_o <= 1'b0;
endtask
// Data is taken one edge late so the registered answer has landed
task automatic rd(input logic [7:0] a, output logic [7:0] d);
	@(posedge clk_i);
	reg_addr_o <= a;
	reg_rd_o   <= 1'b1;
	@(posedge clk_i);
	reg_rd_o <= 1'b0;
	@(posedge clk_i);
	#1 d = reg_rdata_i;
endtask
task automatic ev(input spic_pkg::spic_evt_t e);
	@(posedge clk_i);
	evt_o <= e;
	@(posedge clk_i);
	evt_o <= '0;
	#1;
endtask
task automatic ax();
	@(posedge clk_i);
	axis_rd_o <= 1'b1;
	@(posedge clk_i);
	axis_rd_o <= 1'b0;
endtask
task automatic smp(input logic signed [12:0] v);
	@(posedge clk_i);
	raw_o     <= v;
	raw_vld_o <= 1'b1;
	@(posedge clk_i);
	raw_vld_o <= 1'b0;
	#1;
endtask
endmodule
`default_nettype wire

// *** sim/spic_ctl_tb_top.sv ***
// Top testbench of the power, interrupt and format control block
`timescale 1ns/10ps
`default_nettype none
module spic_ctl_tb_top;
logic                clk_i = 1'b0;
logic                rst_n_i = 1'b0;
logic [7:0]          reg_addr, reg_wdata, reg_rdata;
logic                reg_wr, reg_rd, axis_rd, raw_vld;
spic_pkg::spic_evt_t evt;
logic signed [12:0]  raw;
logic [15:0]         sample;
logic                sample_vld, pin_a, pin_b, meas, slp, fifo_en, act_en, inact_en, st, w3;
logic [3:0]          doze;
int                  bad_count = 0;
int                  comparisons = 0;
logic [7:0]          ofs [5] = '{8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31};
logic [7:0]          rstv [5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
logic [7:0]          msk [5] = '{8'h3F, 8'h9B, 8'h9B, 8'h02, 8'hEF};
////////////////////////////////////////
initial forever #2 clk_i = ~clk_i;
spic_host_model host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
	.reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .evt_o(evt),
	.axis_rd_o(axis_rd), .raw_vld_o(raw_vld), .raw_o(raw));
spic_ctl spic_ctl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
	.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
	.evt_i(evt), .axis_data_read_i(axis_rd), .raw_vld_i(raw_vld), .raw_sample_i(raw),
	.sample_o(sample), .sample_vld_o(sample_vld), .irq_pin_a_o(pin_a), .irq_pin_b_o(pin_b),
	.measure_mode_o(meas), .sleep_mode_o(slp), .fifo_write_en_o(fifo_en), .doze_hz_o(doze),
	.act_detect_en_o(act_en), .inact_detect_en_o(inact_en), .self_test_o(st),
	.wire3_mode_o(w3));
task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
	comparisons++;
	if (g !== e)
	begin
		bad_count++;
		$display("BAD %s expected %h seen %h", n, e, g);
	end
endtask
task automatic rchk(input logic [7:0] a, input logic [7:0] e);
	logic [7:0] d;
	host.rd(a, d);
	chk($sformatf("reg %h", a), 16'(e), 16'(d));
endtask
task automatic tick(input int n);
	repeat (n) @(posedge clk_i);
	#1;
endtask
task automatic wrap_up();
	$display("comparisons %0d bad_count %0d", comparisons, bad_count);
	if (bad_count == 0 && comparisons > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
// Whole run is under two hundred cycles; this leaves a wide margin
initial
begin
	#40000;
	bad_count++;
	wrap_up();
end
initial
begin
	repeat (12) @(posedge clk_i);
	rst_n_i <= 1'b1;
	tick(2);
	foreach (ofs[i]) rchk(ofs[i], rstv[i]);
	foreach (ofs[i]) host.wr(ofs[i], 8'hFF);
	rchk(8'h40, 8'h00);
	foreach (ofs[i]) rchk(ofs[i], msk[i]);
	chk("self_test", 16'h0001, 16'(st));
	chk("wire3", 16'h0001, 16'(w3));
	host.wr(8'h2E, 8'h00);
	host.wr(8'h2F, 8'h00);
	host.wr(8'h31, 8'h00);
	host.wr(8'h2D, 8'h00);
	for (int i = 0; i < 4; i++)
	begin
		host.wr(8'h2D, 8'h08 | 8'(i));
		tick(2);
		chk("doze", 16'(4'h8 >> i), 16'(doze));
		chk("measure", 16'h0001, 16'(meas));
	end
	host.smp(13'h1000);
	chk("sample", 16'hFE00, sample);
	chk("sample_vld", 16'h0001, 16'(sample_vld));
	host.wr(8'h31, 8'h04);
	host.smp(13'h1000);
	chk("sample", 16'h8000, sample);
	host.wr(8'h31, 8'h06);
	host.smp(13'h0400);
	chk("sample", 16'h4000, sample);
	host.wr(8'h31, 8'h09);
	host.smp(13'h0400);
	chk("sample", 16'h03FF, sample);
	host.wr(8'h31, 8'h0B);
	host.smp(13'h1000);
	chk("sample", 16'hF000, sample);
	host.wr(8'h2F, 8'h10);
	host.wr(8'h2E, 8'h10);
	host.ev(5'h08);
	chk("pin_b", 16'h0001, 16'(pin_b));
	chk("pin_a", 16'h0000, 16'(pin_a));
	rchk(8'h30, 8'h12);
	chk("pin_b", 16'h0000, 16'(pin_b));
	host.ax();
	rchk(8'h30, 8'h00);
	host.ev(5'h02);
	rchk(8'h30, 8'h02);
	chk("pin_a", 16'h0000, 16'(pin_a));
	host.wr(8'h2E, 8'h02);
	tick(1);
	chk("pin_a", 16'h0001, 16'(pin_a));
	host.wr(8'h31, 8'h20);
	tick(1);
	chk("pin_a", 16'h0000, 16'(pin_a));
	chk("pin_b", 16'h0001, 16'(pin_b));
	host.wr(8'h31, 8'h00);
	host.wr(8'h2E, 8'h1A);
	tick(2);
	chk("act_en", 16'h0001, 16'(act_en));
	chk("inact_en", 16'h0001, 16'(inact_en));
	host.wr(8'h2D, 8'h0C);
	tick(2);
	chk("sleep", 16'h0001, 16'(slp));
	chk("fifo_en", 16'h0000, 16'(fifo_en));
	chk("inact_en", 16'h0000, 16'(inact_en));
	chk("act_en", 16'h0001, 16'(act_en));
	host.wr(8'h2D, 8'h00);
	tick(2);
	host.smp(13'h0011);
	chk("sample_vld", 16'h0000, 16'(sample_vld));
	chk("measure", 16'h0000, 16'(meas));
	host.wr(8'h2E, 8'h18);
	host.wr(8'h2D, 8'h38);
	host.ev(5'h08);
	host.ev(5'h04);
	tick(2);
	chk("sleep", 16'h0001, 16'(slp));
	rchk(8'h30, 8'h0A);
	host.ev(5'h08);
	tick(2);
	chk("sleep", 16'h0000, 16'(slp));
	host.ev(5'h04);
	tick(2);
	chk("sleep", 16'h0000, 16'(slp));
	rchk(8'h30, 8'h1A);
	host.wr(8'h2D, 8'h00);
	host.wr(8'h2D, 8'h0C);
	host.ev(5'h10);
	rchk(8'h30, 8'h02);
	host.wr(8'h2D, 8'h00);
	host.wr(8'h2D, 8'h08);
	host.ev(5'h11);
	rchk(8'h30, 8'h83);
	host.ax();
	rchk(8'h30, 8'h00);
	wrap_up();
end
endmodule
bind spic_ctl spic_ctl_monitor spic_ctl_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.raw_vld_i(raw_vld_i), .sample_vld_o(sample_vld_o), .measure_mode_o(measure_mode_o),
	.sleep_mode_o(sleep_mode_o), .fifo_write_en_o(fifo_write_en_o), .doze_hz_o(doze_hz_o),
	.inact_detect_en_o(inact_detect_en_o));
`default_nettype wire
